// ===== sensor_offset_and_config_two_tb_top.sv
// self-checking testbench for the offset and second configuration register bank
`timescale 1ns/100ps
`default_nettype none
module sensor_offset_and_config_two_tb_top
  import soct_pkg::*;
;
  // ==========================================================
  // signals
  logic            mclk = 1'b0;
  logic            resetn = 1'b0;
  logic            ce = 1'b1;
  logic            cyc = 1'b0;
  logic            stb = 1'b0;
  logic            we = 1'b0;
  logic [9:0]      adr = 10'h000;
  logic [3:0]      sel = 4'h0;
  logic [31:0]     wdat = 32'h0;
  logic [31:0]     rdat;
  logic            ack;
  soct_temp_t      loc_raw = '0;
  soct_temp_t      rem_raw = '0;
  logic signed [9:0] loc_lim = 10'sh000;
  logic signed [9:0] rem_lim = 10'sh000;
  soct_temp_t      loc_temp;
  soct_temp_t      rem_temp;
  logic            loc_over;
  logic            rem_over;
  logic [2:0]      sense = 3'h0;
  logic [2:0]      drive = 3'h0;
  soct_duty_t      duty_in = '0;
  logic [2:0]      fan_pwm;
  soct_duty_t      duty_out;
  soct_meas_ctrl_t meas;
  logic [8:0]      notes[$];
  int              num_errors = 0;
  int              cmp_count = 0;
  int              cycles = 0;

  soct_regs u_dut (.I_MCLK(mclk), .I_RESETN(resetn), .I_CE(ce), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_LOCAL_RAW(loc_raw), .I_REMOTE2_RAW(rem_raw),
    .I_LOCAL_LIMIT(loc_lim), .I_REMOTE2_LIMIT(rem_lim), .O_LOCAL_TEMP(loc_temp),
    .O_REMOTE2_TEMP(rem_temp), .O_LOCAL_OVER(loc_over), .O_REMOTE2_OVER(rem_over),
    .I_FOUR_WIRE_SENSE(sense), .I_FAN_DRIVE(drive), .I_CUR_DUTY(duty_in),
    .O_FAN_PWM(fan_pwm), .O_CUR_DUTY(duty_out), .O_MEAS_CTRL(meas));

  always #5 mclk = ~mclk;

  // ==========================================================
  // helpers
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle; the note goes in before the request so the monitor finds it
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    input logic [7:0] exp);
    notes.push_back({~w, exp});
    @(posedge mclk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    sel  <= 4'h1;
    wdat <= {24'h0, d};
    do @(posedge mclk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // corrected reading: offset counts two reading steps, clamped to ten bits
  function automatic logic signed [9:0] sat(input logic signed [9:0] r, input logic [7:0] o);
    int s;
    s = int'(r) + 2 * int'($signed(o));
    if (s > 511)
      s = 511;
    if (s < -512)
      s = -512;
    return s[9:0];
  endfunction

  function automatic logic [4:0] onehot(input logic [2:0] m);
    case (m)
      SOCT_SEL_CORE_V:  return 5'h01;
      SOCT_SEL_SUPPLY:  return 5'h02;
      SOCT_SEL_REMOTE1: return 5'h04;
      SOCT_SEL_LOCAL:   return 5'h08;
      SOCT_SEL_REMOTE2: return 5'h10;
      default:          return 5'h00;
    endcase
  endfunction

  task automatic temp_case(input logic signed [9:0] rl, input logic signed [9:0] r2,
                           input logic [7:0] ol, input logic [7:0] o2);
    logic signed [9:0] el;
    logic signed [9:0] e2;
    el = sat(rl, ol);
    e2 = sat(r2, o2);
    wb(1'b1, SOCT_IDX_LOCAL_OFFSET, ol, 8'h00);
    wb(1'b1, SOCT_IDX_REMOTE2_OFFSET, o2, 8'h00);
    wb(1'b0, SOCT_IDX_REMOTE2_OFFSET, 8'h00, o2);
    @(posedge mclk);
    loc_raw <= '{1'b1, rl};
    rem_raw <= '{1'b1, r2};
    loc_lim <= 10'($urandom);
    rem_lim <= 10'($urandom);
    @(posedge mclk);
    loc_raw.valid <= 1'b0;
    rem_raw.valid <= 1'b0;
    #1;
    chk(32'(loc_temp.valid), 32'h1);
    chk(32'(loc_temp.value), 32'(el));
    chk(32'(rem_temp.value), 32'(e2));
    chk(32'(loc_over), 32'(el > loc_lim));
    chk(32'(rem_over), 32'(e2 > rem_lim));
  endtask

  // ==========================================================
  // read monitor: oldest note against each acknowledged read
  always @(posedge mclk)
  begin
    if (ack === 1'b1 && notes.size() > 0)
    begin
      if (notes[0][8])
        chk(rdat, {24'h0, notes[0][7:0]});
      void'(notes.pop_front());
    end
  end

  // hang guard; the whole sequence needs well under two thousand cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(32'h565d5d65));
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    wb(1'b0, SOCT_IDX_LOCAL_OFFSET, 8'h00, 8'h00);
    wb(1'b0, SOCT_IDX_REMOTE2_OFFSET, 8'h00, 8'h00);
    wb(1'b0, SOCT_IDX_CONFIG2, 8'h00, 8'h00);
    wb(1'b0, SOCT_IDX_ALERT_MASK1, 8'h00, 8'h00);
    wb(1'b1, 8'h10, 8'h5a, 8'h00);
    wb(1'b0, 8'h10, 8'h00, 8'h00);
    temp_case(10'sd511, -10'sd512, 8'h7f, 8'h80);
    temp_case(-10'sd3, 10'sd7, 8'hff, 8'h01);
    for (int k = 0; k < 6; k++)
      temp_case(10'($urandom), 10'($urandom), 8'($urandom), 8'($urandom));
    @(posedge mclk);
    sense <= 3'($urandom);
    wb(1'b1, SOCT_IDX_CONFIG2, 8'h0f, 8'h00);
    wb(1'b0, SOCT_IDX_CONFIG2, 8'h00, {4'h0, sense, 1'b1});
    wb(1'b1, SOCT_IDX_CONFIG2, 8'h0e, 8'h00);
    wb(1'b0, SOCT_IDX_CONFIG2, 8'h00, 8'h00);
    for (int m = 0; m < 8; m++)
    begin
      wb(1'b1, SOCT_IDX_CHANNEL_SELECT, {3'(m), 5'h00}, 8'h00);
      wb(1'b1, SOCT_IDX_CONFIG2, {1'b0, 3'(m | 4), 4'h0}, 8'h00);
      @(posedge mclk);
      #1;
      chk(32'(meas), 32'({m[0], m[1], 1'b1, 1'b0, onehot(3'(m))}));
    end
    for (int f = 0; f < 2; f++)
    begin
      @(posedge mclk);
      drive   <= 3'($urandom);
      duty_in <= soct_duty_t'($urandom);
      wb(1'b1, SOCT_IDX_DEVICE_CTRL, {6'h0, 1'(f), 1'b0}, 8'h00);
      wb(1'b1, SOCT_IDX_CONFIG2, 8'h80, 8'h00);
      @(posedge mclk);
      #1;
      chk(32'(fan_pwm), 32'({3{1'(f)}}));
      chk(32'(duty_out), 32'h0);
      chk(32'(meas.power_down_request), 32'h1);
      wb(1'b1, SOCT_IDX_CONFIG2, 8'h00, 8'h00);
      @(posedge mclk);
      #1;
      chk(32'(fan_pwm), 32'(drive));
      chk(32'(duty_out), 32'(duty_in));
      // enable low must freeze the fan outputs at the old drive
      @(posedge mclk);
      ce    <= 1'b0;
      drive <= ~drive;
      repeat (2) @(posedge mclk);
      #1;
      chk(32'(fan_pwm), 32'(3'(~drive)));
      @(posedge mclk);
      ce <= 1'b1;
    end
    wb(1'b1, SOCT_IDX_LOCAL_OFFSET, 8'h21, 8'h00);
    wb(1'b1, SOCT_IDX_REMOTE2_OFFSET, 8'h12, 8'h00);
    wb(1'b1, SOCT_IDX_DEVICE_CTRL, 8'h01, 8'h00);
    wb(1'b1, SOCT_IDX_LOCAL_OFFSET, 8'h55, 8'h00);
    wb(1'b1, SOCT_IDX_REMOTE2_OFFSET, 8'h66, 8'h00);
    wb(1'b1, SOCT_IDX_CONFIG2, 8'hf1, 8'h00);
    wb(1'b1, SOCT_IDX_ALERT_MASK1, 8'h3c, 8'h00);
    wb(1'b0, SOCT_IDX_LOCAL_OFFSET, 8'h00, 8'h21);
    wb(1'b0, SOCT_IDX_REMOTE2_OFFSET, 8'h00, 8'h12);
    wb(1'b0, SOCT_IDX_CONFIG2, 8'h00, 8'h00);
    wb(1'b0, SOCT_IDX_ALERT_MASK1, 8'h00, 8'h3c);
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    wb(1'b1, SOCT_IDX_CONFIG2, 8'h01, 8'h00);
    wb(1'b0, SOCT_IDX_CONFIG2, 8'h00, {4'h0, sense, 1'b1});
    repeat (2) @(posedge mclk);
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== soct_pkg.sv
// constants and carrier types for the offset and second configuration register bank
package soct_pkg;

  // ==========================================================
  // register word indexes (byte address is four times these)
  localparam logic [7:0] SOCT_IDX_LOCAL_OFFSET   = 8'h71;
  localparam logic [7:0] SOCT_IDX_REMOTE2_OFFSET = 8'h72;
  localparam logic [7:0] SOCT_IDX_CONFIG2        = 8'h73;
  localparam logic [7:0] SOCT_IDX_ALERT_MASK1    = 8'h74;
  localparam logic [7:0] SOCT_IDX_CHANNEL_SELECT = 8'h55;
  localparam logic [7:0] SOCT_IDX_DEVICE_CTRL    = 8'h40;

  // ==========================================================
  // reset values
  localparam logic [7:0] SOCT_RST_LOCAL_OFFSET   = 8'h00;
  localparam logic [7:0] SOCT_RST_REMOTE2_OFFSET = 8'h00;
  localparam logic [7:0] SOCT_RST_CONFIG2        = 8'h00;
  localparam logic [7:0] SOCT_RST_ALERT_MASK1    = 8'h00;
  localparam logic [7:0] SOCT_RST_CHANNEL_SELECT = 8'h00;
  localparam logic [1:0] SOCT_RST_DEVICE_CTRL    = 2'h0;

  // ==========================================================
  // field positions
  localparam int unsigned SOCT_CFG_DETECT_EN_BIT = 0;
  localparam int unsigned SOCT_CFG_FLAG_LO       = 1;
  localparam int unsigned SOCT_CFG_FLAG_HI       = 3;
  localparam int unsigned SOCT_CFG_AVG_OFF_BIT   = 4;
  localparam int unsigned SOCT_CFG_BYPASS_BIT    = 5;
  localparam int unsigned SOCT_CFG_SINGLE_BIT    = 6;
  localparam int unsigned SOCT_CFG_PDOWN_BIT     = 7;
  localparam logic [7:0]  SOCT_CFG_RW_MASK       = 8'hf1;
  localparam int unsigned SOCT_SEL_LO            = 5;
  localparam int unsigned SOCT_SEL_HI            = 7;
  localparam int unsigned SOCT_CTRL_LOCK_BIT     = 0;
  localparam int unsigned SOCT_CTRL_FLIP_BIT     = 1;

  // ==========================================================
  // single input selection codes
  localparam logic [2:0] SOCT_SEL_CORE_V  = 3'h1;
  localparam logic [2:0] SOCT_SEL_SUPPLY  = 3'h2;
  localparam logic [2:0] SOCT_SEL_REMOTE1 = 3'h5;
  localparam logic [2:0] SOCT_SEL_LOCAL   = 3'h6;
  localparam logic [2:0] SOCT_SEL_REMOTE2 = 3'h7;

  // ==========================================================
  // sizes; readings carry 0.25 degree per lsb, offsets 0.5, hence one shift
  localparam int unsigned SOCT_NUM_FANS     = 3;
  localparam int unsigned SOCT_TEMP_W       = 10;
  localparam int unsigned SOCT_OFFSET_SHIFT = 1;

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic                          valid;
    logic signed [SOCT_TEMP_W-1:0] value;
  } soct_temp_t;

  typedef struct packed {
    logic       averaging_off;
    logic       core_voltage_divider_bypass;
    logic       single_input_conversion;
    logic       power_down_request;
    logic [4:0] input_onehot;
  } soct_meas_ctrl_t;

  typedef logic [SOCT_NUM_FANS-1:0][7:0] soct_duty_t;

  typedef enum logic {
    SOCT_BUS_IDLE,
    SOCT_BUS_ACK
  } soct_bus_state_t;

endpackage

// ===== soct_regs.sv
// offset and second configuration register bank with wishbone slave
//
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module soct_regs
  import soct_pkg::*;
#(
  parameter int unsigned ADR_W = 10
)
(
  // clock, reset, enable
  input  wire logic                          I_MCLK,
  input  wire logic                          I_RESETN,
  input  wire logic                          I_CE,
  // wishbone slave
  input  wire logic                          I_WB_CYC,
  input  wire logic                          I_WB_STB,
  input  wire logic                          I_WB_WE,
  input  wire logic [ADR_W-1:0]              I_WB_ADR,
  input  wire logic [3:0]                    I_WB_SEL,
  input  wire logic [31:0]                   I_WB_DAT,
  output logic [31:0]                        O_WB_DAT,
  output logic                               O_WB_ACK,
  // temperature readings
  input  wire soct_temp_t                    I_LOCAL_RAW,
  input  wire soct_temp_t                    I_REMOTE2_RAW,
  input  wire logic signed [SOCT_TEMP_W-1:0] I_LOCAL_LIMIT,
  input  wire logic signed [SOCT_TEMP_W-1:0] I_REMOTE2_LIMIT,
  output var  soct_temp_t                    O_LOCAL_TEMP,
  output var  soct_temp_t                    O_REMOTE2_TEMP,
  output logic                               O_LOCAL_OVER,
  output logic                               O_REMOTE2_OVER,
  // fans
  input  wire logic [SOCT_NUM_FANS-1:0]      I_FOUR_WIRE_SENSE,
  input  wire logic [SOCT_NUM_FANS-1:0]      I_FAN_DRIVE,
  input  wire soct_duty_t                    I_CUR_DUTY,
  output logic [SOCT_NUM_FANS-1:0]           O_FAN_PWM,
  output var  soct_duty_t                    O_CUR_DUTY,
  // measurement control
  output var  soct_meas_ctrl_t               O_MEAS_CTRL
);

  // ==========================================================
  // helpers
  function automatic logic idx_hit(input logic [ADR_W-1:0] adr, input logic [7:0] idx);
    idx_hit = (adr[ADR_W-1:2] == idx);
  endfunction

  function automatic logic [4:0] sel_decode(input logic [2:0] code);
    case (code)
      SOCT_SEL_CORE_V:  sel_decode = 5'h01;
      SOCT_SEL_SUPPLY:  sel_decode = 5'h02;
      SOCT_SEL_REMOTE1: sel_decode = 5'h04;
      SOCT_SEL_LOCAL:   sel_decode = 5'h08;
      SOCT_SEL_REMOTE2: sel_decode = 5'h10;
      default:          sel_decode = 5'h00;
    endcase
  endfunction

  // ==========================================================
  // state
  soct_bus_state_t            state_reg;
  soct_bus_state_t            state_next;
  logic                       ack_reg;
  logic                       ack_next;
  logic [31:0]                rdat_reg;
  logic [31:0]                rdat_next;
  logic                       wr_en;
  logic                       wr_open;
  logic [7:0]                 local_off_reg;
  logic [7:0]                 local_off_next;
  logic [7:0]                 remote2_off_reg;
  logic [7:0]                 remote2_off_next;
  logic [7:0]                 cfg_reg;
  logic [7:0]                 cfg_next;
  logic [SOCT_NUM_FANS-1:0]   flags_reg;
  logic [SOCT_NUM_FANS-1:0]   flags_next;
  logic [7:0]                 mask_reg;
  logic [7:0]                 mask_next;
  logic [7:0]                 chsel_reg;
  logic [7:0]                 chsel_next;
  logic [1:0]                 ctrl_reg;
  logic [1:0]                 ctrl_next;
  logic [7:0]                 rd_byte;
  logic [SOCT_NUM_FANS-1:0]   pwm_reg;
  logic [SOCT_NUM_FANS-1:0]   pwm_next;
  soct_duty_t                 duty_reg;
  soct_duty_t                 duty_next;
  soct_meas_ctrl_t            meas_reg;
  soct_meas_ctrl_t            meas_next;
  logic                       locked;
  logic                       pdown;

  assign locked = ctrl_reg[SOCT_CTRL_LOCK_BIT];
  assign pdown  = cfg_reg[SOCT_CFG_PDOWN_BIT];

  // ==========================================================
  // bus slave: ack one cycle after the request, dropped the cycle after
  always_comb
  begin
    state_next = state_reg;
    ack_next   = 1'b0;
    rdat_next  = rdat_reg;
    wr_en      = 1'b0;
    case (state_reg)
      SOCT_BUS_IDLE:
        if (I_WB_CYC && I_WB_STB)
        begin
          state_next = SOCT_BUS_ACK;
          ack_next   = 1'b1;
          rdat_next  = {24'h000000, rd_byte};
          wr_en      = I_WB_WE && I_WB_SEL[0];
        end
      SOCT_BUS_ACK:
        state_next = SOCT_BUS_IDLE;
      default:
        state_next = SOCT_BUS_IDLE;
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      state_reg <= SOCT_BUS_IDLE;
      ack_reg   <= 1'b0;
      rdat_reg  <= 32'h00000000;
    end
    else if (I_CE)
    begin
      state_reg <= state_next;
      ack_reg   <= ack_next;
      rdat_reg  <= rdat_next;
    end
  end

  // ==========================================================
  // read mux; unmapped words read zero
  always_comb
  begin
    rd_byte = 8'h00;
    if (idx_hit(I_WB_ADR, SOCT_IDX_LOCAL_OFFSET))
      rd_byte = local_off_reg;
    else if (idx_hit(I_WB_ADR, SOCT_IDX_REMOTE2_OFFSET))
      rd_byte = remote2_off_reg;
    else if (idx_hit(I_WB_ADR, SOCT_IDX_CONFIG2))
      rd_byte = cfg_reg | {4'h0, flags_reg, 1'b0};
    else if (idx_hit(I_WB_ADR, SOCT_IDX_ALERT_MASK1))
      rd_byte = mask_reg;
    else if (idx_hit(I_WB_ADR, SOCT_IDX_CHANNEL_SELECT))
      rd_byte = chsel_reg;
    else if (idx_hit(I_WB_ADR, SOCT_IDX_DEVICE_CTRL))
      rd_byte = {6'h00, ctrl_reg};
  end

  // ==========================================================
  // register file
  always_comb
  begin
    wr_open          = wr_en && !locked;
    local_off_next   = local_off_reg;
    remote2_off_next = remote2_off_reg;
    cfg_next         = cfg_reg;
    mask_next        = mask_reg;
    chsel_next       = chsel_reg;
    ctrl_next        = ctrl_reg;
    if (wr_open && idx_hit(I_WB_ADR, SOCT_IDX_LOCAL_OFFSET))
      local_off_next = I_WB_DAT[7:0];
    if (wr_open && idx_hit(I_WB_ADR, SOCT_IDX_REMOTE2_OFFSET))
      remote2_off_next = I_WB_DAT[7:0];
    // flag bits are not stored here, so software cannot write them
    if (wr_open && idx_hit(I_WB_ADR, SOCT_IDX_CONFIG2))
      cfg_next = I_WB_DAT[7:0] & SOCT_CFG_RW_MASK;
    if (wr_en && idx_hit(I_WB_ADR, SOCT_IDX_ALERT_MASK1))
      mask_next = I_WB_DAT[7:0];
    if (wr_en && idx_hit(I_WB_ADR, SOCT_IDX_CHANNEL_SELECT))
      chsel_next = I_WB_DAT[7:0];
    if (wr_en && idx_hit(I_WB_ADR, SOCT_IDX_DEVICE_CTRL))
    begin
      // lock is sticky: only reset releases it
      ctrl_next[SOCT_CTRL_LOCK_BIT] = locked | I_WB_DAT[SOCT_CTRL_LOCK_BIT];
      ctrl_next[SOCT_CTRL_FLIP_BIT] = I_WB_DAT[SOCT_CTRL_FLIP_BIT];
    end
    flags_next = cfg_reg[SOCT_CFG_DETECT_EN_BIT] ? I_FOUR_WIRE_SENSE
                                                 : '0;
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      local_off_reg   <= SOCT_RST_LOCAL_OFFSET;
      remote2_off_reg <= SOCT_RST_REMOTE2_OFFSET;
      cfg_reg         <= SOCT_RST_CONFIG2;
      flags_reg       <= '0;
      mask_reg        <= SOCT_RST_ALERT_MASK1;
      chsel_reg       <= SOCT_RST_CHANNEL_SELECT;
      ctrl_reg        <= SOCT_RST_DEVICE_CTRL;
    end
    else if (I_CE)
    begin
      local_off_reg   <= local_off_next;
      remote2_off_reg <= remote2_off_next;
      cfg_reg         <= cfg_next;
      flags_reg       <= flags_next;
      mask_reg        <= mask_next;
      chsel_reg       <= chsel_next;
      ctrl_reg        <= ctrl_next;
    end
  end

  // ==========================================================
  // fan outputs and measurement control
  always_comb
  begin
    // fan drive arrives already polarity-adjusted; only shutdown overrides it
    pwm_next  = pdown ? {SOCT_NUM_FANS{ctrl_reg[SOCT_CTRL_FLIP_BIT]}} : I_FAN_DRIVE;
    duty_next = pdown ? '0 : I_CUR_DUTY;
    meas_next.averaging_off               = cfg_reg[SOCT_CFG_AVG_OFF_BIT];
    meas_next.core_voltage_divider_bypass = cfg_reg[SOCT_CFG_BYPASS_BIT];
    meas_next.single_input_conversion     = cfg_reg[SOCT_CFG_SINGLE_BIT];
    meas_next.power_down_request          = pdown;
    // reserved codes give no selection at all
    meas_next.input_onehot = cfg_reg[SOCT_CFG_SINGLE_BIT]
                           ? sel_decode(chsel_reg[SOCT_SEL_HI:SOCT_SEL_LO])
                           : 5'h00;
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      pwm_reg  <= '0;
      duty_reg <= '0;
      meas_reg <= '0;
    end
    else if (I_CE)
    begin
      pwm_reg  <= pwm_next;
      duty_reg <= duty_next;
      meas_reg <= meas_next;
    end
  end

  // ==========================================================
  // temperature channels: 0 local, 1 second remote
  soct_temp_t                    raw_arr   [2];
  soct_temp_t                    temp_arr  [2];
  logic [7:0]                    off_arr   [2];
  logic signed [SOCT_TEMP_W-1:0] limit_arr [2];
  logic [1:0]                    over_arr;

  assign raw_arr[0]   = I_LOCAL_RAW;
  assign raw_arr[1]   = I_REMOTE2_RAW;
  assign off_arr[0]   = local_off_reg;
  assign off_arr[1]   = remote2_off_reg;
  assign limit_arr[0] = I_LOCAL_LIMIT;
  assign limit_arr[1] = I_REMOTE2_LIMIT;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      soct_temp_correct u_corr (
        .i_clk    (I_MCLK),
        .i_resetn (I_RESETN),
        .i_ce     (I_CE),
        .i_raw    (raw_arr[ch]),
        .i_offset (off_arr[ch]),
        .i_limit  (limit_arr[ch]),
        .o_temp   (temp_arr[ch]),
        .o_over   (over_arr[ch])
      );
    end
  endgenerate

  // ==========================================================
  // outputs
  assign O_WB_ACK       = ack_reg;
  assign O_WB_DAT       = rdat_reg;
  assign O_LOCAL_TEMP   = temp_arr[0];
  assign O_REMOTE2_TEMP = temp_arr[1];
  assign O_LOCAL_OVER   = over_arr[0];
  assign O_REMOTE2_OVER = over_arr[1];
  assign O_FAN_PWM      = pwm_reg;
  assign O_CUR_DUTY     = duty_reg;
  assign O_MEAS_CTRL    = meas_reg;

  // ==========================================================
  // checks
  property p_lock_blocks;
    @(posedge I_MCLK) disable iff (!I_RESETN)
    I_CE && locked && wr_en && idx_hit(I_WB_ADR, SOCT_IDX_CONFIG2)
    |=> $stable(cfg_reg) ##1 $stable(cfg_reg);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks)
    else $error("config changed by a write while locked");

  property p_detect_flags;
    @(posedge I_MCLK) disable iff (!I_RESETN)
    I_CE && cfg_reg[SOCT_CFG_DETECT_EN_BIT]
    |=> flags_reg == $past(I_FOUR_WIRE_SENSE);
  endproperty
  a_detect_flags: assert property (p_detect_flags)
    else $error("fan flags do not follow sense inputs");

  property p_flags_idle;
    @(posedge I_MCLK) disable iff (!I_RESETN)
    I_CE && !cfg_reg[SOCT_CFG_DETECT_EN_BIT] |=> flags_reg == '0;
  endproperty
  a_flags_idle: assert property (p_flags_idle)
    else $error("fan flags set while detection disabled");

  property p_avg_follow;
    @(posedge I_MCLK) disable iff (!I_RESETN)
    I_CE && $changed(cfg_reg[SOCT_CFG_AVG_OFF_BIT])
    |=> O_MEAS_CTRL.averaging_off == $past(cfg_reg[SOCT_CFG_AVG_OFF_BIT]);
  endproperty
  a_avg_follow: assert property (p_avg_follow)
    else $error("averaging control lags config");

  property p_bypass_follow;
    @(posedge I_MCLK) disable iff (!I_RESETN)
    I_CE |=> O_MEAS_CTRL.core_voltage_divider_bypass == $past(cfg_reg[SOCT_CFG_BYPASS_BIT]);
  endproperty
  a_bypass_follow: assert property (p_bypass_follow)
    else $error("divider bypass does not follow config");

  property p_sel_remote1;
    @(posedge I_MCLK) disable iff (!I_RESETN)
    I_CE && cfg_reg[SOCT_CFG_SINGLE_BIT] && chsel_reg[SOCT_SEL_HI:SOCT_SEL_LO] == 3'h5
    |=> O_MEAS_CTRL.single_input_conversion && O_MEAS_CTRL.input_onehot == 5'h04;
  endproperty
  a_sel_remote1: assert property (p_sel_remote1)
    else $error("single input selection wrong");

  property p_fans_off;
    @(posedge I_MCLK) disable iff (!I_RESETN)
    I_CE && pdown
    |=> O_FAN_PWM == {SOCT_NUM_FANS{$past(ctrl_reg[SOCT_CTRL_FLIP_BIT])}} && O_CUR_DUTY == '0;
  endproperty
  a_fans_off: assert property (p_fans_off)
    else $error("fans not off in shutdown");

  property p_ack_pulse;
    @(posedge I_MCLK) disable iff (!I_RESETN)
    I_CE && O_WB_ACK |=> !O_WB_ACK;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// ===== soct_temp_correct.sv
// offset correction and limit compare for one temperature channel
`timescale 1ns/100ps
`default_nettype none
module soct_temp_correct
  import soct_pkg::*;
(
  // clock, reset and enable
  input  wire logic                          i_clk,
  input  wire logic                          i_resetn,
  input  wire logic                          i_ce,
  // reading in
  input  wire soct_temp_t                    i_raw,
  input  wire logic [7:0]                    i_offset,
  input  wire logic signed [SOCT_TEMP_W-1:0] i_limit,
  // corrected reading out
  output var  soct_temp_t                    o_temp,
  output logic                               o_over
);

  // ==========================================================
  // saturating add
  localparam logic signed [SOCT_TEMP_W:0] MAX_V = 11'sh1ff;
  localparam logic signed [SOCT_TEMP_W:0] MIN_V = -11'sh200;

  logic signed [SOCT_TEMP_W:0]   sum;
  logic signed [SOCT_TEMP_W-1:0] sat;
  soct_temp_t                    temp_reg;
  soct_temp_t                    temp_next;
  logic                          over_reg;
  logic                          over_next;

  always_comb
  begin
    sum = {i_raw.value[SOCT_TEMP_W-1], i_raw.value}
        + (SOCT_TEMP_W+1)'($signed(i_offset) <<< SOCT_OFFSET_SHIFT);
    if (sum > MAX_V)
      sat = MAX_V[SOCT_TEMP_W-1:0];
    else if (sum < MIN_V)
      sat = MIN_V[SOCT_TEMP_W-1:0];
    else
      sat = sum[SOCT_TEMP_W-1:0];
    temp_next.valid = i_raw.valid;
    temp_next.value = i_raw.valid ? sat : temp_reg.value;
    // compare the corrected value, never the raw one
    over_next = i_raw.valid ? (sat > i_limit) : over_reg;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      temp_reg <= '0;
      over_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      temp_reg <= temp_next;
      over_reg <= over_next;
    end
  end

  assign o_temp = temp_reg;
  assign o_over = over_reg;

  // ==========================================================
  // checks
  property p_offset_added;
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && i_raw.valid && (i_raw.value < 10'sh0ff) && (i_raw.value > -10'sh0ff)
    |=> (o_temp.value == $past(i_raw.value) + 2 * $signed($past(i_offset)));
  endproperty
  a_offset_added: assert property (p_offset_added)
    else $error("corrected reading does not carry the offset");

  property p_over_corrected;
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && i_raw.valid |=> (o_over == (o_temp.value > $past(i_limit)));
  endproperty
  a_over_corrected: assert property (p_over_corrected)
    else $error("limit flag not based on corrected reading");

endmodule
`default_nettype wire
